// file: rtl/svr_index_dec.sv
// Register index decoder for the vector register file.
// Assumes prefix bits come straight from the instruction decoder.
module svr_index_dec (
   input  wire logic                     long_mode,
   input  wire logic                     prefix_valid,
   input  wire logic                     prefix_ext,
   input  wire logic                     prefix_meaningful,
   input  wire logic [2:0]               idx_low,
   output logic      [svr_pkg::IDX_W-1:0] idx
);
   logic ext_used;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Outside long mode the prefix does not exist
   assign ext_used = long_mode & prefix_valid
                   & prefix_meaningful & prefix_ext;
   assign idx = {ext_used, idx_low};

endmodule : svr_index_dec

// file: rtl/svr_pkg.sv
// Package for the vector register file: widths, indices, reset values.
// Assumes one core clock and a synchronous active-low reset.
package svr_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int unsigned VEC_W      = 128;
   localparam int unsigned LANE_W     = 32;
   localparam int unsigned LANES      = 4;
   localparam int unsigned NREG_LEG   = 8;
   localparam int unsigned NREG_LONG  = 16;
   localparam int unsigned IDX_W      = 4;
   localparam int unsigned PIR_N      = 8;
   localparam int unsigned PIR_W      = 64;
   localparam int unsigned GPR_W      = 64;
   localparam int unsigned BYTES_VEC  = 16;

   // ----------------------------------------------------------------
   // Identification
   // ----------------------------------------------------------------
   localparam logic [31:0] ID_LEAF     = 32'h0000_0001;
   localparam int unsigned ID_FEAT_BIT = 25;

   // ----------------------------------------------------------------
   // Control and status register
   // ----------------------------------------------------------------
   localparam logic [31:0] CSR_RESET   = 32'h0000_1f80;
   localparam logic [31:0] CSR_RSV_MSK = 32'hffff_0000;
   localparam int unsigned CSR_MSK_LO  = 7;
   localparam int unsigned CSR_MSK_HI  = 12;

   // ----------------------------------------------------------------
   // Transfer sizes, source selects and operating modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SVR_SZ_32  = 2'b00,
      SVR_SZ_64  = 2'b01,
      SVR_SZ_128 = 2'b10
   } svr_size_e;

   typedef enum logic [1:0] {
      SVR_SRC_MEM = 2'b00,
      SVR_SRC_GPR = 2'b01,
      SVR_SRC_PIR = 2'b10,
      SVR_SRC_ALU = 2'b11
   } svr_src_e;

   typedef enum logic [1:0] {
      SVR_MODE_REAL = 2'b00,
      SVR_MODE_PROT = 2'b01,
      SVR_MODE_V86  = 2'b10,
      SVR_MODE_LONG = 2'b11
   } svr_mode_e;

endpackage : svr_pkg

// file: rtl/svr_regfile.sv
// Vector register file: data registers, control/status, feature bit.
// Assumes decoder and execution units drive one write per cycle.
//
// Function
// - Identification leaf one returns feature bit 25 set in result D.
// - Eight 128-bit registers normally; sixteen in 64-bit mode.
// - Upper eight registers reachable only with the extension prefix bit.
// - Extension prefix without meaning is ignored.
// - Width bit of prefix selects full 64-bit general register.
// - Scalar operations touch only the lowest doubleword.
// - Vector storage is separate, aliased to no other register.
// - Loads and stores move 32, 64 or 128 bits.
// - Full store puts register bits 7:0 at lowest byte address.
// - Vector and packed-integer registers never feed address generation.
// - One 32-bit control and status register.
// - Some compares return results in the processor flags register.
// - Compatibility mode behaves as protected mode.
// - Extension usable in protected, real and virtual-8086 modes.
// - Packed operand is four single-precision values in four doublewords.
// - Packed-integer registers can source or receive transfers.
// - Control bits 31:16 reserved, zero; non-zero load faults.
// - Reset sets the six exception mask bits.
module svr_regfile #(
   parameter int unsigned NREG = svr_pkg::NREG_LONG
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_n,
   input  wire logic                          long_mode,
   input  wire logic                          compat_mode,
   // Identification
   input  wire logic                          id_req,
   input  wire logic [31:0]                   id_leaf,
   output logic      [31:0]                   id_result_register_d,
   // Prefix decode
   input  wire logic                          prefix_valid,
   input  wire logic                          prefix_ext_dst,
   input  wire logic                          prefix_ext_src,
   input  wire logic                          prefix_meaningful,
   input  wire logic                          operand_width_prefix_bit,
   // Read port
   input  wire logic [2:0]                    rd_idx_low,
   output logic      [svr_pkg::VEC_W-1:0]     rd_data,
   output logic      [7:0]                    rd_bytes [svr_pkg::BYTES_VEC],
   // Write port
   input  wire logic                          wr_en,
   input  wire logic [2:0]                    wr_idx_low,
   input  wire svr_pkg::svr_src_e             wr_src,
   input  wire svr_pkg::svr_size_e            wr_size,
   input  wire logic                          wr_scalar,
   input  wire logic [svr_pkg::VEC_W-1:0]     wr_data,
   input  wire logic [svr_pkg::GPR_W-1:0]     gpr_data,
   input  wire logic [2:0]                    pir_sel,
   input  wire logic [svr_pkg::PIR_W-1:0]     pir_data [svr_pkg::PIR_N],
   output logic      [svr_pkg::PIR_W-1:0]     pir_out,
   output logic      [svr_pkg::GPR_W-1:0]     gpr_out,
   // Compare into flags
   input  wire logic                          cmp_en,
   input  wire logic [31:0]                   cmp_flags,
   output logic                               flags_we,
   output logic      [31:0]                   processor_flags_register,
   // Control and status register
   input  wire logic                          csr_we,
   input  wire logic [31:0]                   csr_wdata,
   input  wire logic [5:0]                    csr_status_set,
   output logic      [31:0]                   vector_ctrl_status_reg,
   output logic                               gp_fault,
   // Address generation
   input  wire logic [svr_pkg::GPR_W-1:0]     agu_base_gpr,
   input  wire logic [svr_pkg::GPR_W-1:0]     agu_index_gpr,
   output logic      [svr_pkg::GPR_W-1:0]     agu_addr
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NREG-1:0][svr_pkg::VEC_W-1:0] vreg;
      logic [31:0]                         csr;
      logic [31:0]                         id_res;
      logic                                fault;
      logic [31:0]                         flags;
      logic                                flags_we;
   } svr_state_s;

   svr_state_s st;
   svr_state_s next_st;

   logic [svr_pkg::IDX_W-1:0] wr_idx;
   logic [svr_pkg::IDX_W-1:0] rd_idx;
   logic [svr_pkg::VEC_W-1:0] src_vec;
   logic [svr_pkg::VEC_W-1:0] merged;
   logic [svr_pkg::GPR_W-1:0] gpr_sel;
   logic                      wide_mode;

   // ----------------------------------------------------------------
   // Index decode
   // ----------------------------------------------------------------
   // Compat mode has no extension prefix, exactly as protected mode
   assign wide_mode = long_mode & ~compat_mode;

   svr_index_dec u_wr_dec (
      .long_mode         (wide_mode),
      .prefix_valid      (prefix_valid),
      .prefix_ext        (prefix_ext_dst),
      .prefix_meaningful (prefix_meaningful),
      .idx_low           (wr_idx_low),
      .idx               (wr_idx)
   );

   svr_index_dec u_rd_dec (
      .long_mode         (wide_mode),
      .prefix_valid      (prefix_valid),
      .prefix_ext        (prefix_ext_src),
      .prefix_meaningful (prefix_meaningful),
      .idx_low           (rd_idx_low),
      .idx               (rd_idx)
   );

   // ----------------------------------------------------------------
   // Reads
   // ----------------------------------------------------------------
   assign rd_data = st.vreg[rd_idx[$clog2(NREG)-1:0]];

   // Byte 0 is the lowest memory address
   for (genvar b = 0; b < svr_pkg::BYTES_VEC; b++) begin : g_bytes
      assign rd_bytes[b] = rd_data[8*b +: 8];
   end

   assign pir_out = rd_data[svr_pkg::PIR_W-1:0];
   assign gpr_out = operand_width_prefix_bit
                  ? rd_data[svr_pkg::GPR_W-1:0]
                  : {32'h0, rd_data[31:0]};

   // Only general registers reach the address adder
   assign agu_addr = agu_base_gpr + agu_index_gpr;

   assign vector_ctrl_status_reg   = st.csr;
   assign id_result_register_d     = st.id_res;
   assign gp_fault                 = st.fault;
   assign processor_flags_register = st.flags;
   assign flags_we                 = st.flags_we;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      gpr_sel = operand_width_prefix_bit
              ? gpr_data
              : {32'h0, gpr_data[31:0]};
      unique case (wr_src)
         svr_pkg::SVR_SRC_GPR: src_vec = {64'h0, gpr_sel};
         svr_pkg::SVR_SRC_PIR: src_vec = {64'h0, pir_data[pir_sel]};
         default:              src_vec = wr_data;
      endcase
      merged = st.vreg[wr_idx[$clog2(NREG)-1:0]];
      // Mode bits gate nothing: all modes use the same path
      if (wr_scalar) begin
         merged[svr_pkg::LANE_W-1:0] = src_vec[svr_pkg::LANE_W-1:0];
      end else begin
         unique case (wr_size)
            svr_pkg::SVR_SZ_32:
               merged[31:0] = src_vec[31:0];
            svr_pkg::SVR_SZ_64:
               merged[63:0] = src_vec[63:0];
            default:
               merged = src_vec;
         endcase
      end
      // Own storage; no other register file shares it
      if (wr_en) begin
         next_st.vreg[wr_idx[$clog2(NREG)-1:0]] = merged;
      end
      // Sticky status flags, set wins over a load
      next_st.fault = 1'b0;
      if (csr_we) begin
         if ((csr_wdata & svr_pkg::CSR_RSV_MSK) != 32'h0) begin
            next_st.fault = 1'b1;
         end else begin
            next_st.csr = csr_wdata;
         end
      end
      next_st.csr[5:0] = next_st.csr[5:0] | csr_status_set;
      next_st.id_res = 32'h0;
      if (id_req && id_leaf == svr_pkg::ID_LEAF) begin
         next_st.id_res[svr_pkg::ID_FEAT_BIT] = 1'b1;
      end
      next_st.flags_we = cmp_en;
      if (cmp_en) begin
         next_st.flags = cmp_flags;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st       <= '0;
         st.csr   <= svr_pkg::CSR_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_id_bit;
      @(posedge clk_sys) disable iff (!rst_n)
      (id_req && id_leaf == svr_pkg::ID_LEAF) |=> id_result_register_d[25];
   endproperty
   a_id_bit: assert property (p_id_bit) else $error("feature bit missing");

   property p_rsv_zero;
      @(posedge clk_sys) disable iff (!rst_n)
      vector_ctrl_status_reg[31:16] == 16'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved set");

   property p_rsv_fault;
      @(posedge clk_sys) disable iff (!rst_n)
      (csr_we && csr_wdata[31:16] != 16'h0) |=> gp_fault;
   endproperty
   a_rsv_fault: assert property (p_rsv_fault) else $error("no fault");

   property p_csr_load;
      @(posedge clk_sys) disable iff (!rst_n)
      (csr_we && csr_wdata[31:16] == 16'h0 && csr_status_set == 6'h0)
         |=> vector_ctrl_status_reg == $past(csr_wdata) && !gp_fault;
   endproperty
   a_csr_load: assert property (p_csr_load) else $error("csr not loaded");

   property p_mask_reset;
      @(posedge clk_sys) $rose(rst_n) |-> vector_ctrl_status_reg[12:7] == 6'h3f;
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("masks clear");

   property p_no_upper;
      @(posedge clk_sys) disable iff (!rst_n)
      !long_mode |-> wr_idx[3] == 1'b0 && rd_idx[3] == 1'b0;
   endproperty
   a_no_upper: assert property (p_no_upper) else $error("upper reg used");

   property p_prefix_ignored;
      @(posedge clk_sys) disable iff (!rst_n)
      !prefix_meaningful |-> wr_idx == {1'b0, wr_idx_low};
   endproperty
   a_prefix_ignored: assert property (p_prefix_ignored) else $error("prefix used");

   property p_scalar_upper;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_en && wr_scalar && rd_idx == wr_idx)
         |=> rd_data[127:32] == $past(rd_data[127:32]) || rd_idx != $past(rd_idx);
   endproperty
   a_scalar_upper: assert property (p_scalar_upper) else $error("upper lanes hit");

   property p_flags;
      @(posedge clk_sys) disable iff (!rst_n)
      cmp_en |=> flags_we && processor_flags_register == $past(cmp_flags);
   endproperty
   a_flags: assert property (p_flags) else $error("flags not written");

   property p_byte0;
      @(posedge clk_sys) disable iff (!rst_n)
      rd_bytes[0] == rd_data[7:0] && rd_bytes[15] == rd_data[127:120];
   endproperty
   a_byte0: assert property (p_byte0) else $error("byte order");

   property p_compat_lower;
      @(posedge clk_sys) disable iff (!rst_n)
      compat_mode |-> wr_idx[3] == 1'b0 && rd_idx[3] == 1'b0;
   endproperty
   a_compat_lower: assert property (p_compat_lower) else $error("compat upper");

   property p_upper_reach;
      @(posedge clk_sys) disable iff (!rst_n)
      (wide_mode && prefix_valid && prefix_meaningful)
         |-> wr_idx[3] == prefix_ext_dst && rd_idx[3] == prefix_ext_src;
   endproperty
   a_upper_reach: assert property (p_upper_reach) else $error("upper missed");

   property p_write_lands;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_en && !wr_scalar && wr_size == svr_pkg::SVR_SZ_128
         && wr_src == svr_pkg::SVR_SRC_MEM && rd_idx == wr_idx)
         |=> rd_data == $past(wr_data) || rd_idx != $past(rd_idx);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("write lost");

   property p_partial_keep;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_en && !wr_scalar && wr_size == svr_pkg::SVR_SZ_64
         && rd_idx == wr_idx)
         |=> rd_data[127:64] == $past(rd_data[127:64]) || rd_idx != $past(rd_idx);
   endproperty
   a_partial_keep: assert property (p_partial_keep) else $error("high lanes hit");

   property p_pir_move;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_en && !wr_scalar && wr_src == svr_pkg::SVR_SRC_PIR
         && wr_size == svr_pkg::SVR_SZ_64 && rd_idx == wr_idx)
         |=> rd_data[63:0] == $past(pir_data[pir_sel])
             || rd_idx != $past(rd_idx);
   endproperty
   a_pir_move: assert property (p_pir_move) else $error("packed move lost");

   property p_gpr_narrow;
      @(posedge clk_sys) disable iff (!rst_n)
      !operand_width_prefix_bit |-> gpr_out[63:32] == 32'h0;
   endproperty
   a_gpr_narrow: assert property (p_gpr_narrow) else $error("gpr not narrow");

   property p_id_other;
      @(posedge clk_sys) disable iff (!rst_n)
      !(id_req && id_leaf == svr_pkg::ID_LEAF) |=> id_result_register_d == 32'h0;
   endproperty
   a_id_other: assert property (p_id_other) else $error("stray id bits");

   property p_fault_pulse;
      @(posedge clk_sys) disable iff (!rst_n)
      !csr_we |=> !gp_fault;
   endproperty
   a_fault_pulse: assert property (p_fault_pulse) else $error("stray fault");

   property p_rsv_keep;
      @(posedge clk_sys) disable iff (!rst_n)
      (csr_we && csr_wdata[31:16] != 16'h0 && csr_status_set == 6'h0)
         |=> $stable(vector_ctrl_status_reg);
   endproperty
   a_rsv_keep: assert property (p_rsv_keep) else $error("refused load landed");

   property p_status_set;
      @(posedge clk_sys) disable iff (!rst_n)
      csr_status_set != 6'h0 |=> (vector_ctrl_status_reg[5:0]
         & $past(csr_status_set)) == $past(csr_status_set);
   endproperty
   a_status_set: assert property (p_status_set) else $error("flag set lost");

   property p_csr_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      (!csr_we && csr_status_set == 6'h0) |=> $stable(vector_ctrl_status_reg);
   endproperty
   a_csr_hold: assert property (p_csr_hold) else $error("csr drifted");

   property p_flags_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      !cmp_en |=> !flags_we && $stable(processor_flags_register);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags drifted");

   property p_vreg_reset;
      @(posedge clk_sys) $rose(rst_n) |-> rd_data == 128'h0;
   endproperty
   a_vreg_reset: assert property (p_vreg_reset) else $error("data not cleared");

endmodule : svr_regfile

// file: sim/simd_vector_register_file_bench.sv
// Self-checking bench for the vector register file.
// Assumes the design samples every request on the rising clock edge.
module simd_vector_register_file_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic               clk_sys = 1'b0;
   logic               rst_n, long_mode, compat_mode, id_req, refresh;
   logic               prefix_valid, ext_dst, ext_src, meaningful, width_bit;
   logic               wr_en, wr_scalar, cmp_en, flags_we, csr_we, gp_fault;
   logic [2:0]         rd_idx_low, wr_idx_low, pir_sel;
   logic [31:0]        id_leaf, id_res, cmp_flags, flags, csr_wdata, csr, r;
   logic [127:0]       rd_data, wr_data, exp;
   logic [7:0]         rd_bytes [16];
   logic [63:0]        pir_data [8];
   logic [63:0]        gpr_data, pir_out, gpr_out, seed_val, base, index, agu;
   logic [5:0]         csr_status_set;
   logic [127:0]       mdl [16];
   svr_pkg::svr_src_e  wr_src;
   svr_pkg::svr_size_e wr_size;
   int                 n_errors, compares, seed;

   always #2 clk_sys = ~clk_sys;

   svr_core_model svr_core_model_inst (.clk_sys(clk_sys), .refresh(refresh),
      .seed_val(seed_val), .pir_data(pir_data), .gpr_data(gpr_data));

   svr_regfile svr_regfile_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .long_mode(long_mode), .compat_mode(compat_mode), .id_req(id_req),
      .id_leaf(id_leaf), .id_result_register_d(id_res),
      .prefix_valid(prefix_valid), .prefix_ext_dst(ext_dst),
      .prefix_ext_src(ext_src), .prefix_meaningful(meaningful),
      .operand_width_prefix_bit(width_bit), .rd_idx_low(rd_idx_low),
      .rd_data(rd_data), .rd_bytes(rd_bytes), .wr_en(wr_en),
      .wr_idx_low(wr_idx_low), .wr_src(wr_src), .wr_size(wr_size),
      .wr_scalar(wr_scalar), .wr_data(wr_data), .gpr_data(gpr_data),
      .pir_sel(pir_sel), .pir_data(pir_data), .pir_out(pir_out),
      .gpr_out(gpr_out), .cmp_en(cmp_en), .cmp_flags(cmp_flags),
      .flags_we(flags_we), .processor_flags_register(flags),
      .csr_we(csr_we), .csr_wdata(csr_wdata),
      .csr_status_set(csr_status_set), .vector_ctrl_status_reg(csr),
      .gp_fault(gp_fault), .agu_base_gpr(base), .agu_index_gpr(index),
      .agu_addr(agu));

   // ----------------------------------------------------------------
   // Expectation helpers and checks
   // ----------------------------------------------------------------
   function automatic int f_idx(input logic ext, input logic [2:0] low);
      return (ext && long_mode && !compat_mode && prefix_valid && meaningful)
             ? 8 + low : low;
   endfunction : f_idx

   function automatic logic [127:0] f_merge(input logic [127:0] old, nw,
         input svr_pkg::svr_size_e sz, input logic sc);
      if (sc || sz == svr_pkg::SVR_SZ_32) return {old[127:32], nw[31:0]};
      if (sz == svr_pkg::SVR_SZ_64) return {old[127:64], nw[63:0]};
      return nw;
   endfunction : f_merge

   task automatic chk_vec(input string what, input logic [127:0] e, g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk_vec

   task automatic chk_flag(input string what, input logic e, g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %b seen %b", what, e, g);
      end
   endtask : chk_flag

   task automatic tick;
      @(negedge clk_sys);
   endtask : tick

   // Leaves wr_en high so writes can run back to back
   task automatic vwrite(input logic ext, input logic [2:0] low,
         input svr_pkg::svr_src_e src, input svr_pkg::svr_size_e sz,
         input logic sc, input logic [127:0] d,
         input logic rext, input logic [2:0] rlow);
      int k;
      k = f_idx(ext, low);
      wr_en = 1'b1;
      wr_idx_low = low;
      ext_dst = ext;
      wr_src = src;
      wr_size = sz;
      wr_scalar = sc;
      wr_data = d;
      if (src == svr_pkg::SVR_SRC_PIR) d = {64'h0, seed_val ^ {8{5'h0, pir_sel}}};
      if (src == svr_pkg::SVR_SRC_GPR) begin
         d = {64'h0, width_bit ? ~seed_val : {32'h0, ~seed_val[31:0]}};
      end
      // Read in the write cycle still sees the old contents
      vread(rext, rlow);
      mdl[k] = f_merge(mdl[k], d, sz, sc);
      tick;
   endtask : vwrite

   task automatic vread(input logic ext, input logic [2:0] low);
      rd_idx_low = low;
      ext_src = ext;
      #1;
      exp = mdl[f_idx(ext, low)];
      chk_vec("rd_data", exp, rd_data);
      for (int b = 0; b < 16; b++) begin
         chk_vec("rd_bytes", 128'(exp[8*b +: 8]), 128'(rd_bytes[b]));
      end
      chk_vec("pir_out", 128'(exp[63:0]), 128'(pir_out));
      chk_vec("gpr_out", width_bit ? 128'(exp[63:0]) : 128'(exp[31:0]),
              128'(gpr_out));
   endtask : vread

   task automatic test_done;
      $display("Comparisons %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h00a1;
      {rst_n, long_mode, compat_mode, id_req, prefix_valid, ext_dst} = '0;
      {ext_src, meaningful, width_bit, wr_en, wr_scalar, cmp_en, csr_we} = '0;
      {rd_idx_low, wr_idx_low, pir_sel, id_leaf, cmp_flags, csr_wdata} = '0;
      {wr_data, base, index, csr_status_set} = '0;
      wr_src = svr_pkg::SVR_SRC_MEM;
      wr_size = svr_pkg::SVR_SZ_128;
      refresh = 1'b1;
      seed_val = {$random(seed), $random(seed)};
      for (int i = 0; i < 16; i++) mdl[i] = '0;
      repeat (20) tick;
      refresh = 1'b0;
      rst_n = 1'b1;
      chk_vec("csr", 128'(svr_pkg::CSR_RESET), 128'(csr));
      {long_mode, prefix_valid, meaningful} = 3'b111;
      for (int i = 0; i < 16; i++) begin
         vread(i[3], i[2:0]);
         tick;
      end
      // Identification: leaf one then another leaf, back to back
      id_req = 1'b1;
      id_leaf = svr_pkg::ID_LEAF;
      tick;
      chk_vec("id", 128'(32'h1 << svr_pkg::ID_FEAT_BIT), 128'(id_res));
      id_leaf = 32'h0000_0002;
      tick;
      chk_vec("id", 128'h0, 128'(id_res));
      id_req = 1'b0;
      // Random modes, prefixes, sources and sizes; reads see prior writes
      for (int n = 0; n < 300; n++) begin
         r = $random(seed);
         {long_mode, prefix_valid, meaningful, compat_mode, width_bit} = r[12:8];
         pir_sel = r[15:13];
         vwrite(r[20], r[23:21], svr_pkg::svr_src_e'(r[1:0]),
                r[3] ? svr_pkg::SVR_SZ_128 : svr_pkg::svr_size_e'({1'b0, r[4]}),
                r[5] & r[6], {$random(seed), $random(seed), $random(seed),
                $random(seed)}, r[16], r[19:17]);
      end
      wr_en = 1'b0;
      {long_mode, prefix_valid, meaningful, compat_mode} = 4'b1110;
      for (int i = 0; i < 16; i++) begin
         vread(i[3], i[2:0]);
         tick;
      end
      // Reserved control bits refused, then a legal load and sticky flags
      csr_we = 1'b1;
      for (int b = 16; b < 32; b += 15) begin
         csr_wdata = 32'h1 << b;
         tick;
         chk_flag("gp_fault", 1'b1, gp_fault);
         chk_vec("csr", 128'(svr_pkg::CSR_RESET), 128'(csr));
      end
      csr_wdata = 32'h0000_6040;
      tick;
      chk_flag("gp_fault", 1'b0, gp_fault);
      chk_vec("csr", 128'h6040, 128'(csr));
      csr_we = 1'b0;
      csr_status_set = 6'h15;
      tick;
      chk_vec("csr", 128'h6055, 128'(csr));
      // Flag set and clearing load in one cycle: the set wins
      {csr_we, csr_wdata, csr_status_set} = {1'b1, 32'h0, 6'h2a};
      tick;
      {csr_we, csr_status_set} = '0;
      chk_vec("csr", 128'h2a, 128'(csr));
      // Compare results land in the flags register for one strobe
      cmp_en = 1'b1;
      cmp_flags = $random(seed);
      tick;
      cmp_en = 1'b0;
      chk_flag("flags_we", 1'b1, flags_we);
      chk_vec("flags", 128'(cmp_flags), 128'(flags));
      tick;
      chk_flag("flags_we", 1'b0, flags_we);
      // Address generation from general registers only
      for (int n = 0; n < 8; n++) begin
         base = {$random(seed), $random(seed)};
         index = {$random(seed), $random(seed)};
         #1;
         chk_vec("agu", 128'(64'(base + index)), 128'(agu));
         tick;
      end
      // Second reset mid-run restores the masks
      rst_n = 1'b0;
      tick;
      rst_n = 1'b1;
      chk_vec("csr", 128'(svr_pkg::CSR_RESET), 128'(csr));
      chk_flag("gp_fault", 1'b0, gp_fault);
      for (int i = 0; i < 16; i++) mdl[i] = '0;
      for (int i = 0; i < 16; i++) begin
         vread(i[3], i[2:0]);
         tick;
      end
      test_done();
   end

   // Watchdog well beyond the few hundred cycles of the sequence
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      test_done();
   end
endmodule : simd_vector_register_file_bench

// file: sim/svr_core_model.sv
// Core-side model: packed-integer registers and a general register source.
// Assumes the bench pulses refresh while the register file is in reset.
module svr_core_model (
   input  wire logic                      clk_sys,
   input  wire logic                      refresh,
   input  wire logic [svr_pkg::PIR_W-1:0] seed_val,
   output logic      [svr_pkg::PIR_W-1:0] pir_data [svr_pkg::PIR_N],
   output logic      [svr_pkg::GPR_W-1:0] gpr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Packed-integer bank
   // ----------------------------------------------------------------
   // Distinct per-register values so a wrong select shows
   always_ff @(posedge clk_sys) begin
      if (refresh) begin
         for (int i = 0; i < svr_pkg::PIR_N; i++) begin
            pir_data[i] <= seed_val ^ {8{8'(i)}};
         end
         gpr_data <= ~seed_val;
      end
   end
endmodule : svr_core_model
